/* dv/dcc_ctrl_checker.sv */
// Checker for the decoded controls of dcc_ctrl.
// Assumes it sees only the top module ports; it is bound below.
`timescale 1ns/1ps
module dcc_ctrl_checker
	import dcc_pkg::*;
(
	// Clock, reset and strobes.
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       io_update,
	input wire logic       profile_change,
	input wire logic       power_down_control_pin,
	// Decoded controls.
	input wire logic       aux_active_q,
	input wire dcc_route_t aux_route_q,
	input wire logic       keying_phase_q,
	input wire logic       modulus_mode_q,
	input wire logic       dc_full_scale_q,
	input wire logic       dds_out_off_q,
	input wire logic       trig_state_q,
	input wire logic       sweep_return_q,
	input wire logic       digital_off_q,
	input wire logic       dac_digital_off_q,
	input wire logic       dac_analog_off_q,
	input wire logic       pll_off_q,
	input wire logic       clock_gen_off_q,
	input wire logic       aux_clear_q,
	input wire logic       phase_clear_q,
	input wire logic       sine_select_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// A transfer two edges back; the enable, trigger and waveform levels may move only then.
	sequence xfer_two_back;
		$past(io_update | profile_change, 2);
	endsequence
	chk_hold_until_xfer: assert property ($changed({aux_active_q, trig_state_q, sine_select_q}) |-> xfer_two_back)
		else $error("decoded level moved without a transfer");
	chk_aux_clear_pulse: assert property (aux_clear_q |-> $past(io_update))
		else $error("aux clear without update strobe");
	chk_phase_clear_pulse: assert property (phase_clear_q |-> $past(io_update))
		else $error("phase clear without update strobe");
	chk_dc_needs_aux: assert property (dc_full_scale_q |-> aux_active_q && dds_out_off_q)
		else $error("full scale without sweep");
	chk_dwell_needs_aux: assert property (sweep_return_q |-> aux_active_q)
		else $error("return without sweep");
	chk_modulus_route: assert property (modulus_mode_q |-> aux_active_q && aux_route_q == DCC_ROUTE_NONE)
		else $error("modulus mode routed");
	chk_phase_route: assert property (keying_phase_q && aux_active_q && !modulus_mode_q |-> aux_route_q == DCC_ROUTE_PHASE)
		else $error("phase keying not routed to phase");
	chk_full_pd_all: assert property (pll_off_q |-> dac_analog_off_q && clock_gen_off_q && digital_off_q)
		else $error("full power down incomplete");
	chk_fast_pd_pin: assert property (power_down_control_pin [*6] |-> digital_off_q && dac_digital_off_q)
		else $error("pin did not power down logic");
endmodule : dcc_ctrl_checker

bind dcc_ctrl dcc_ctrl_checker dcc_ctrl_checker_i (.*);

/* dv/testbench.sv */
// Bench for dcc_ctrl: a table of control words, then strobe cases.
// Assumes the design and the checker are compiled first.
`timescale 1ns/1ps
module testbench;
	import dcc_pkg::*;
	// Inputs, all given values at time zero.
	logic ref_clk = 1'h0, rst_n = 1'h0, host_wr = 1'h0, host_rd = 1'h0, io_update = 1'h0;
	logic profile_change = 1'h0, power_down_control_pin = 1'h0;
	logic [7:0] host_addr = 8'h00;
	logic [31:0] host_wdata = 32'h0;
	logic [15:0] sweep_ramp_rate = 16'h0040;
	// Outputs.
	logic [31:0] host_rdata_q;
	dcc_route_t aux_route_q;
	logic aux_active_q, keying_phase_q, modulus_mode_q, dc_full_scale_q, dds_out_off_q, trig_state_q;
	logic sweep_return_q, digital_off_q, dac_digital_off_q, dac_analog_off_q, pll_off_q, clock_gen_off_q;
	logic aux_clear_q, phase_clear_q, sine_select_q, ramp_tick_q;
	logic [15:0] ramp_timer_q;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	// One row: pin level, control word, decoded controls expected.
	typedef struct {logic pin; logic [31:0] w; logic [14:0] e;} dcc_row_t;
	dcc_row_t rows [8] = '{'{1'h0, 32'h0000_0800, 15'h5000}, '{1'h0, 32'h0000_1D01, 15'h6B41},
		'{1'h0, 32'h0000_0771, 15'h00BB}, '{1'h0, 32'h1000_0800, 15'h4400}, '{1'h0, 32'h0000_1000, 15'h0800},
		'{1'h0, 32'h0000_0080, 15'h0000}, '{1'h1, 32'h0000_0000, 15'h0030}, '{1'h1, 32'h0000_0080, 15'h003E}};
	wire [14:0] obs = {aux_active_q, aux_route_q, keying_phase_q, modulus_mode_q, dc_full_scale_q, dds_out_off_q,
		trig_state_q, sweep_return_q, digital_off_q, dac_digital_off_q, dac_analog_off_q, pll_off_q,
		clock_gen_off_q, sine_select_q};
	dcc_ctrl dcc_ctrl_i (.*);
	always #2 ref_clk = ~ref_clk;
	task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	// Each driver starts on an edge, so no strobe is assigned twice in one step.
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge ref_clk);
		host_wr <= 1'h1;
		host_addr <= a;
		host_wdata <= d;
		@(posedge ref_clk);
		host_wr <= 1'h0;
	endtask : wr
	task automatic upd(logic prof);
		@(posedge ref_clk);
		io_update <= ~prof;
		profile_change <= prof;
		@(posedge ref_clk);
		io_update <= 1'h0;
		profile_change <= 1'h0;
	endtask : upd
	task automatic rd(logic [7:0] a, logic [31:0] exp);
		@(posedge ref_clk);
		host_rd <= 1'h1;
		host_addr <= a;
		@(posedge ref_clk);
		host_rd <= 1'h0;
		#1;
		cmp("read data", exp, host_rdata_q);
	endtask : rd
	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop
	// A hang is cut short well beyond the roughly 150 cycles needed.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			report_and_stop();
		end
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		#1;
		cmp("reset controls", 32'h0, 32'(obs));
		cmp("reset timer", 32'h1, 32'(ramp_timer_q));
		@(posedge ref_clk);
		rst_n <= 1'h1;
		foreach (rows[i]) begin
			@(posedge ref_clk);
			power_down_control_pin <= rows[i].pin;
			wr(8'h00, rows[i].w);
			upd(1'h0);
			repeat (6) @(posedge ref_clk);
			#1;
			cmp("decoded", 32'(rows[i].e), 32'(obs));
			rd(8'h00, rows[i].w);
		end
		// Writes without a transfer, and to an unmapped address, stay invisible.
		@(posedge ref_clk);
		power_down_control_pin <= 1'h0;
		wr(8'h00, 32'h0000_0001);
		wr(8'h05, 32'hFFFF_FFFF);
		repeat (6) @(posedge ref_clk);
		#1;
		cmp("held", 32'h0, 32'(obs));
		rd(8'h05, 32'h0);
		rd(8'h00, 32'h0000_0001);
		upd(1'h1);
		repeat (2) @(posedge ref_clk);
		#1;
		cmp("profile transfer", 32'h1, 32'(obs));
		// Auto-clear pulses for one cycle on the update strobe only.
		wr(8'h00, 32'h0000_0006);
		upd(1'h0);
		#1;
		cmp("clear pulse", 32'h3, {30'h0, aux_clear_q, phase_clear_q});
		@(posedge ref_clk);
		#1;
		cmp("clear width", 32'h0, {30'h0, aux_clear_q, phase_clear_q});
		upd(1'h1);
		#1;
		cmp("no clear on profile", 32'h0, {30'h0, aux_clear_q, phase_clear_q});
		// Immediate rate reload once the reload bit is active.
		wr(8'h00, 32'h0000_0008);
		upd(1'h0);
		sweep_ramp_rate <= 16'h0123;
		upd(1'h0);
		#1;
		cmp("timer reload", 32'h0123, 32'(ramp_timer_q));
		report_and_stop();
	end
endmodule : testbench

/* rtl/dcc_ctrl.sv */
// Control register low half: host write, update-strobe transfer and decoded controls.
// Assumes the host port and update strobe are synchronous to ref_clk; the power-down pin is not.
`timescale 1ns/1ps

// Functional notes
// - Destination zero: frequency keying and frequency sweep.
// - Destination one: phase keying and phase sweep.
// - Enable bit activates the auxiliary accumulator.
// - DC bit forces full scale during sweep.
// - Trigger bit picks edge or state sweep.
// - No-dwell returns sweep to start value.
// - Fast pin power-down affects digital logic only.
// - Full pin power-down shuts every function.
// - Digital power-down bit idles the core.
// - DAC power-down bit idles the converter.
// - Clock power-down bit stops all clocks.
// - Reload clear: timer finishes, then loads rate.
// - Reload set: update strobe reloads timer now.
// - Aux auto-clear zeroes accumulator one cycle.
// - Phase auto-clear zeroes accumulator one cycle.
// - Waveform bit: zero cosine, one sine.
// - Written bits act only after update strobe or profile change.
// - Modulus bit replaces sweep with modulus use.
module dcc_ctrl
	import dcc_pkg::*;
(
	// Clock and reset.
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// Host register port.
	input  wire logic              host_wr,
	input  wire logic              host_rd,
	input  wire logic [7:0]        host_addr,
	input  wire logic [31:0]       host_wdata,
	output logic      [31:0]       host_rdata_q,
	// Update strobe and profile change, both on ref_clk.
	input  wire logic              io_update,
	input  wire logic              profile_change,
	// External power-down pin, asynchronous.
	input  wire logic              power_down_control_pin,
	// New sweep ramp rate value for the ramp timer.
	input  wire logic [RATE_W-1:0] sweep_ramp_rate,
	// Decoded controls to the core.
	output logic                   aux_active_q,
	output dcc_route_t             aux_route_q,
	output logic                   keying_phase_q,
	output logic                   modulus_mode_q,
	output logic                   dc_full_scale_q,
	output logic                   dds_out_off_q,
	output logic                   trig_state_q,
	output logic                   sweep_return_q,
	output logic                   digital_off_q,
	output logic                   dac_digital_off_q,
	output logic                   dac_analog_off_q,
	output logic                   pll_off_q,
	output logic                   clock_gen_off_q,
	output logic                   aux_clear_q,
	output logic                   phase_clear_q,
	output logic                   sine_select_q,
	// Ramp rate timer state.
	output logic [RATE_W-1:0]      ramp_timer_q,
	output logic                   ramp_tick_q
);

	// Shadow copy written by the host and active copy used by the core.
	logic [31:0]       shadow_q, shadow_d;
	logic [31:0]       active_q, active_d;
	// Two-stage synchroniser for the power-down pin.
	logic              pd_meta_q, pd_sync_q;
	// Ramp timer, its reload value and the pending reload value.
	logic [RATE_W-1:0] timer_d, rate_q, rate_d;
	logic              tick_d;
	// Next values of the decoded outputs.
	logic              aux_active_d, keying_phase_d, modulus_d, dc_d, dds_off_d;
	logic              trig_d, ret_d, dig_off_d, dacd_off_d, daca_off_d, pll_off_d;
	logic              clk_off_d, aux_clr_d, ph_clr_d, sine_d;
	dcc_route_t        route_d;
	logic [31:0]       rdata_d;
	logic              transfer;
	logic              sweep_on;

	// Transfer to the active copy happens on the update strobe or a profile change.
	assign transfer = io_update | profile_change;

	// Register copies: host writes only touch the shadow copy, so nothing reaches the core early.
	always_comb begin
		shadow_d = shadow_q;
		active_d = active_q;
		rdata_d  = host_rdata_q;
		if (host_wr && host_addr == CTRL1_ADDR) begin
			shadow_d = host_wdata;
		end
		if (transfer) begin
			active_d = shadow_d;
		end
		if (host_rd) begin
			// Unmapped reads return zero rather than stale data.
			rdata_d = (host_addr == CTRL1_ADDR) ? shadow_q : 32'h0000_0000;
		end
	end

	// Sweep behaviour only matters while the auxiliary accumulator runs as a sweep.
	assign sweep_on = active_q[AUX_EN_BIT];

	// Decode of the active copy into the controls the core consumes.
	always_comb begin
		aux_active_d   = active_q[AUX_EN_BIT];
		// Modulus selection is only honoured with sweep enabled.
		modulus_d      = sweep_on & active_q[MOD_EN_BIT];
		// Destination values other than zero are not defended in modulus mode.
		keying_phase_d = (active_q[DEST_HI_BIT:DEST_LO_BIT] == DEST_PHASE);
		if (!sweep_on || modulus_d) begin
			route_d = DCC_ROUTE_NONE;
		end else if (active_q[DEST_HI_BIT:DEST_LO_BIT] == DEST_FREQ) begin
			route_d = DCC_ROUTE_FREQ;
		end else if (active_q[DEST_HI_BIT:DEST_LO_BIT] == DEST_PHASE) begin
			route_d = DCC_ROUTE_PHASE;
		end else begin
			route_d = DCC_ROUTE_NONE;
		end
		dc_d      = sweep_on & active_q[DC_OUT_BIT];
		dds_off_d = dc_d;
		trig_d    = active_q[TRIG_STATE_BIT];
		ret_d     = sweep_on & active_q[NO_DWELL_BIT];
		// Pin power-down: fast mode spares analog, PLL and clocks; full mode hits all.
		dig_off_d  = active_q[DIG_PD_BIT] | pd_sync_q;
		dacd_off_d = active_q[DAC_PD_BIT] | pd_sync_q;
		daca_off_d = active_q[DAC_PD_BIT] | (pd_sync_q & active_q[EXT_PD_FULL_BIT]);
		pll_off_d  = pd_sync_q & active_q[EXT_PD_FULL_BIT];
		clk_off_d  = active_q[CLK_PD_BIT] | (pd_sync_q & active_q[EXT_PD_FULL_BIT]);
		// Clear pulses use the value being transferred so a set-and-update acts at once.
		aux_clr_d = io_update & shadow_d[AUX_CLR_BIT];
		ph_clr_d  = io_update & shadow_d[PHASE_CLR_BIT];
		sine_d    = active_q[SINE_BIT];
	end

	// Ramp rate timer: counts down; reload policy chosen by the reload bit.
	always_comb begin
		rate_d  = rate_q;
		timer_d = ramp_timer_q;
		tick_d  = 1'b0;
		if (io_update) begin
			rate_d = sweep_ramp_rate;
		end
		if (io_update && shadow_d[RELOAD_BIT]) begin
			timer_d = sweep_ramp_rate;
		end else if (ramp_timer_q <= RATE_RESET) begin
			// Expiry: only now does a pending rate take effect.
			timer_d = rate_d;
			tick_d  = 1'b1;
		end else begin
			timer_d = ramp_timer_q - RATE_RESET;
		end
	end

	// Power-down pin synchroniser; the first stage feeds only the second.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pd_meta_q <= 1'b0;
			pd_sync_q <= 1'b0;
		end else begin
			pd_meta_q <= power_down_control_pin;
			pd_sync_q <= pd_meta_q;
		end
	end

	// All registered state and outputs except the pin synchroniser.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			shadow_q          <= CTRL1_RESET;
			active_q          <= CTRL1_RESET;
			host_rdata_q      <= 32'h0000_0000;
			aux_active_q      <= 1'b0;
			aux_route_q       <= DCC_ROUTE_NONE;
			keying_phase_q    <= 1'b0;
			modulus_mode_q    <= 1'b0;
			dc_full_scale_q   <= 1'b0;
			dds_out_off_q     <= 1'b0;
			trig_state_q      <= 1'b0;
			sweep_return_q    <= 1'b0;
			digital_off_q     <= 1'b0;
			dac_digital_off_q <= 1'b0;
			dac_analog_off_q  <= 1'b0;
			pll_off_q         <= 1'b0;
			clock_gen_off_q   <= 1'b0;
			aux_clear_q       <= 1'b0;
			phase_clear_q     <= 1'b0;
			sine_select_q     <= 1'b0;
			rate_q            <= RATE_RESET;
			ramp_timer_q      <= RATE_RESET;
			ramp_tick_q       <= 1'b0;
		end else begin
			shadow_q          <= shadow_d;
			active_q          <= active_d;
			host_rdata_q      <= rdata_d;
			aux_active_q      <= aux_active_d;
			aux_route_q       <= route_d;
			keying_phase_q    <= keying_phase_d;
			modulus_mode_q    <= modulus_d;
			dc_full_scale_q   <= dc_d;
			dds_out_off_q     <= dds_off_d;
			trig_state_q      <= trig_d;
			sweep_return_q    <= ret_d;
			digital_off_q     <= dig_off_d;
			dac_digital_off_q <= dacd_off_d;
			dac_analog_off_q  <= daca_off_d;
			pll_off_q         <= pll_off_d;
			clock_gen_off_q   <= clk_off_d;
			aux_clear_q       <= aux_clr_d;
			phase_clear_q     <= ph_clr_d;
			sine_select_q     <= sine_d;
			rate_q            <= rate_d;
			ramp_timer_q      <= timer_d;
			ramp_tick_q       <= tick_d;
		end
	end

endmodule : dcc_ctrl

/* shared/dcc_pkg.sv */
// Package for the control register low-half block of the synthesizer core.
// Assumes a single 250 MHz reference clock and a host port that presents whole 32-bit words.
package dcc_pkg;

	// Register address of the first control register on the host port.
	localparam logic [7:0]  CTRL1_ADDR      = 8'h00;
	// Reset value of the first control register; all control bits start cleared.
	localparam logic [31:0] CTRL1_RESET     = 32'h0000_0000;

	// Field positions inside the first control register.
	localparam int          MOD_EN_BIT      = 28;
	localparam int          DEST_HI_BIT     = 13;
	localparam int          DEST_LO_BIT     = 12;
	localparam int          AUX_EN_BIT      = 11;
	localparam int          DC_OUT_BIT      = 10;
	localparam int          TRIG_STATE_BIT  = 9;
	localparam int          NO_DWELL_BIT    = 8;
	localparam int          EXT_PD_FULL_BIT = 7;
	localparam int          DIG_PD_BIT      = 6;
	localparam int          DAC_PD_BIT      = 5;
	localparam int          CLK_PD_BIT      = 4;
	localparam int          RELOAD_BIT      = 3;
	localparam int          AUX_CLR_BIT     = 2;
	localparam int          PHASE_CLR_BIT   = 1;
	localparam int          SINE_BIT        = 0;

	// Destination field encodings.
	localparam logic [1:0]  DEST_FREQ       = 2'h0;
	localparam logic [1:0]  DEST_PHASE      = 2'h1;

	// Width of the sweep ramp rate timer.
	localparam int          RATE_W          = 16;
	localparam logic [15:0] RATE_RESET      = 16'h0001;

	// Where the auxiliary accumulator output is steered.
	typedef enum logic [1:0] {
		DCC_ROUTE_NONE,
		DCC_ROUTE_FREQ,
		DCC_ROUTE_PHASE
	} dcc_route_t;

endpackage : dcc_pkg
